//--- rtl/pmr_router.v
// Purpose: Peripheral region decoder, interrupt source routing and clock-gate routing
// Assumes: One clock, synchronous active-high reset, one clock enable
// Notes: All outputs are registered, so selects and peripheral sources lag their causes by one cycle; pin sources also pass the synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "pmr_consts.vh"

module pmr_router
(
  // Clock, reset, enable
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  // Master access request
  input wire ACC_VALID,
  input wire [31:0] ACC_ADDR,
  // Access decode results
  output reg [19:0] WIN_SEL,
  output reg [1:0] ACC_RESULT,
  // System peripheral interrupts
  input wire IRQ_DRAM,
  input wire IRQ_DEBUG,
  input wire IRQ_PIT,
  input wire IRQ_RTT,
  input wire IRQ_WDOG,
  input wire IRQ_RSTC,
  input wire IRQ_PMC,
  // Peripheral interrupts
  input wire IRQ_IOA,
  input wire IRQ_IOB,
  input wire IRQ_SER0,
  input wire IRQ_SER1,
  input wire IRQ_SERIAL_PERIPH_IF_ZERO,
  input wire [2:0] IRQ_TIMER,
  input wire IRQ_USB,
  input wire IRQ_CONV,
  input wire [13:0] IRQ_USER,
  input wire IRQ_MASTER_A,
  input wire IRQ_MASTER_B,
  // External interrupt pins, asynchronous
  input wire FAST_INT_PIN,
  input wire EXT_INT0_PIN,
  input wire EXT_INT1_PIN,
  // Clock enables from the power manager, indexed by identifier
  input wire [31:0] PCLK_EN_ID,
  // Interrupt controller sources, indexed by identifier
  output reg [31:0] INT_SRC,
  // Per-peripheral clock enables
  output reg SYS_CLK_EN,
  output reg IOA_CLK_EN,
  output reg IOB_CLK_EN,
  output reg SER0_CLK_EN,
  output reg SER1_CLK_EN,
  output reg SERIAL_PERIPH_IF_ZERO_CLK_EN,
  output reg [2:0] TIMER_CLK_EN,
  output reg USB_CLK_EN,
  output reg CONV_CLK_EN,
  output reg [13:0] USER_CLK_EN,
  output reg MASTER_A_CLK_EN,
  output reg MASTER_B_CLK_EN
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Region membership, used for decode and miss reporting
  function in_region;
    input [31:0] a;
    begin
      in_region = (a >= `PMR_REGION_BASE) && (a <= `PMR_REGION_LAST);
    end
  endfunction

  // Window number: offset from base divided by 16 KB
  function [4:0] win_index;
    input [31:0] a;
    reg [31:0] off;
    begin
      off = a - `PMR_REGION_BASE;
      win_index = off[`PMR_WIN_SHIFT+`PMR_WIN_IDX_W-1:`PMR_WIN_SHIFT];
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  reg [2:0] fast_sync_reg;
  reg [2:0] ext0_sync_reg;
  reg [2:0] ext1_sync_reg;
  reg fast_level_reg;
  reg ext0_level_reg;
  reg ext1_level_reg;

  // Three stages; level changes only when stages two and three agree
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      fast_sync_reg <= 3'h0;
      ext0_sync_reg <= 3'h0;
      ext1_sync_reg <= 3'h0;
      fast_level_reg <= 1'b0;
      ext0_level_reg <= 1'b0;
      ext1_level_reg <= 1'b0;
    end
    else if (CE)
    begin
      fast_sync_reg <= {fast_sync_reg[1:0], FAST_INT_PIN};
      ext0_sync_reg <= {ext0_sync_reg[1:0], EXT_INT0_PIN};
      ext1_sync_reg <= {ext1_sync_reg[1:0], EXT_INT1_PIN};
      if (fast_sync_reg[1] == fast_sync_reg[2])
        fast_level_reg <= fast_sync_reg[2];
      if (ext0_sync_reg[1] == ext0_sync_reg[2])
        ext0_level_reg <= ext0_sync_reg[2];
      if (ext1_sync_reg[1] == ext1_sync_reg[2])
        ext1_level_reg <= ext1_sync_reg[2];
    end
  end

  // ==========================================================
  // Address decode
  // ==========================================================
  reg [19:0] win_sel_next;
  reg [1:0] acc_result_next;
  reg [4:0] widx;

  // One-hot select; no select at all outside the region
  always @*
  begin
    widx = win_index(ACC_ADDR);
    win_sel_next = 20'h00000;
    acc_result_next = `PMR_ACCESS_NONE;
    if (ACC_VALID)
    begin
      if (in_region(ACC_ADDR))
      begin
        win_sel_next[widx] = 1'b1;
        acc_result_next = `PMR_ACCESS_HIT;
      end
      else
        acc_result_next = `PMR_ACCESS_MISS;
    end
  end

  // ==========================================================
  // Interrupt source routing
  // ==========================================================
  reg [31:0] int_src_next;

  // Each identifier bit carries its peripheral's interrupt; bits 8, 9, 28 and 29 stay low
  always @*
  begin
    int_src_next = 32'h00000000;
    int_src_next[`PMR_ID_FAST] = fast_level_reg;
    int_src_next[`PMR_ID_SYS] = IRQ_DRAM | IRQ_DEBUG | IRQ_PIT | IRQ_RTT | IRQ_WDOG | IRQ_RSTC | IRQ_PMC;
    int_src_next[`PMR_ID_IOA] = IRQ_IOA;
    int_src_next[`PMR_ID_IOB] = IRQ_IOB;
    int_src_next[`PMR_ID_SER0] = IRQ_SER0;
    int_src_next[`PMR_ID_SER1] = IRQ_SER1;
    int_src_next[`PMR_ID_SERIAL_PERIPH_IF_ZERO] = IRQ_SERIAL_PERIPH_IF_ZERO;
    // Shared source; software must poll all three channels
    int_src_next[`PMR_ID_TIMER] = |IRQ_TIMER;
    int_src_next[`PMR_ID_USB] = IRQ_USB;
    int_src_next[`PMR_ID_CONV] = IRQ_CONV;
    int_src_next[`PMR_ID_USER0+:`PMR_USER_COUNT] = IRQ_USER;
    int_src_next[`PMR_ID_MASTER_A] = IRQ_MASTER_A;
    int_src_next[`PMR_ID_MASTER_B] = IRQ_MASTER_B;
    int_src_next[`PMR_ID_EXT0] = ext0_level_reg;
    int_src_next[`PMR_ID_EXT1] = ext1_level_reg;
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  // Clock enables default on so peripherals run out of reset
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      WIN_SEL <= 20'h00000;
      ACC_RESULT <= `PMR_ACCESS_NONE;
      INT_SRC <= 32'h00000000;
      SYS_CLK_EN <= 1'b1;
      IOA_CLK_EN <= 1'b1;
      IOB_CLK_EN <= 1'b1;
      SER0_CLK_EN <= 1'b1;
      SER1_CLK_EN <= 1'b1;
      SERIAL_PERIPH_IF_ZERO_CLK_EN <= 1'b1;
      TIMER_CLK_EN <= `PMR_TIMER_EN_ON;
      USB_CLK_EN <= 1'b1;
      CONV_CLK_EN <= 1'b1;
      USER_CLK_EN <= `PMR_USER_EN_ON;
      MASTER_A_CLK_EN <= 1'b1;
      MASTER_B_CLK_EN <= 1'b1;
    end
    else if (CE)
    begin
      WIN_SEL <= win_sel_next;
      ACC_RESULT <= acc_result_next;
      INT_SRC <= int_src_next;
      // System clock is never gated; bit 1 of the enables is ignored
      SYS_CLK_EN <= 1'b1;
      IOA_CLK_EN <= PCLK_EN_ID[`PMR_ID_IOA];
      IOB_CLK_EN <= PCLK_EN_ID[`PMR_ID_IOB];
      SER0_CLK_EN <= PCLK_EN_ID[`PMR_ID_SER0];
      SER1_CLK_EN <= PCLK_EN_ID[`PMR_ID_SER1];
      SERIAL_PERIPH_IF_ZERO_CLK_EN <= PCLK_EN_ID[`PMR_ID_SERIAL_PERIPH_IF_ZERO];
      // Bits 8 and 9 ignored: channels gate only as a group
      TIMER_CLK_EN <= {3{PCLK_EN_ID[`PMR_ID_TIMER]}};
      USB_CLK_EN <= PCLK_EN_ID[`PMR_ID_USB];
      CONV_CLK_EN <= PCLK_EN_ID[`PMR_ID_CONV];
      USER_CLK_EN <= PCLK_EN_ID[`PMR_ID_USER0+:`PMR_USER_COUNT];
      MASTER_A_CLK_EN <= PCLK_EN_ID[`PMR_ID_MASTER_A];
      MASTER_B_CLK_EN <= PCLK_EN_ID[`PMR_ID_MASTER_B];
    end
  end

endmodule // pmr_router
`default_nettype wire

//--- shared/pmr_consts.vh
// Purpose: Constants for the peripheral map and identifier router
// Assumes: 32-bit byte addresses, 32 identifiers
// Notes: Windows are 16 KB, numbered from the region base
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH
`define PMR_REGION_BASE 32'hFFFA0000
`define PMR_REGION_LAST 32'hFFFEFFFF
`define PMR_WIN_SHIFT 14
`define PMR_WIN_COUNT 20
`define PMR_WIN_IDX_W 5
`define PMR_ADDR_W 32
`define PMR_ID_COUNT 32
`define PMR_USER_COUNT 14
`define PMR_ACCESS_NONE 2'h0
`define PMR_ACCESS_HIT 2'h1
`define PMR_ACCESS_MISS 2'h2
// Clock enables run out of reset
`define PMR_TIMER_EN_ON 3'h7
`define PMR_USER_EN_ON 14'h3FFF
// Window numbers in ascending address order
`define PMR_WIN_TIMER 5'h00
`define PMR_WIN_USB 5'h01
`define PMR_WIN_CONV 5'h02
`define PMR_WIN_SERIAL_PERIPH_IF_ZERO 5'h03
`define PMR_WIN_SER0 5'h04
`define PMR_WIN_SER1 5'h05
`define PMR_WIN_USER0 5'h06
// Identifier numbers
`define PMR_ID_FAST 5'h00
`define PMR_ID_SYS 5'h01
`define PMR_ID_IOA 5'h02
`define PMR_ID_IOB 5'h03
`define PMR_ID_SER0 5'h04
`define PMR_ID_SER1 5'h05
`define PMR_ID_SERIAL_PERIPH_IF_ZERO 5'h06
`define PMR_ID_TIMER 5'h07
`define PMR_ID_TIMER1 5'h08
`define PMR_ID_TIMER2 5'h09
`define PMR_ID_USB 5'h0A
`define PMR_ID_CONV 5'h0B
`define PMR_ID_USER0 5'h0C
`define PMR_ID_MASTER_A 5'h1A
`define PMR_ID_MASTER_B 5'h1B
`define PMR_ID_UNUSED0 5'h1C
`define PMR_ID_UNUSED1 5'h1D
`define PMR_ID_EXT0 5'h1E
`define PMR_ID_EXT1 5'h1F
`endif

//--- tb/peripheral_map_and_id_routing_bench.sv
// Purpose: Self-checking bench for the router
// Assumes: 100 MHz clock, reset held 5 cycles
// Notes: Each scenario drives, waits one edge (six for pins, three with enable low) and judges
`timescale 1ns/10ps
`default_nettype none
module peripheral_map_and_id_routing_bench;
  // Inputs, quiet at time zero
  logic CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, IRQ_MASTER_A = 1'b0, IRQ_MASTER_B = 1'b0;
  logic IRQ_DRAM = 1'b0, IRQ_DEBUG = 1'b0, IRQ_PIT = 1'b0, IRQ_RTT = 1'b0, IRQ_WDOG = 1'b0, IRQ_RSTC = 1'b0;
  logic IRQ_PMC = 1'b0, IRQ_IOA = 1'b0, IRQ_IOB = 1'b0, IRQ_SER0 = 1'b0, IRQ_SER1 = 1'b0, IRQ_SERIAL_PERIPH_IF_ZERO = 1'b0;
  logic IRQ_USB = 1'b0, IRQ_CONV = 1'b0, FAST_INT_PIN = 1'b0, EXT_INT0_PIN = 1'b0, EXT_INT1_PIN = 1'b0;
  logic [2:0] IRQ_TIMER = 3'h0;
  logic [13:0] IRQ_USER = 14'h0;
  logic [31:0] PCLK_EN_ID = 32'hFFFFFFFF;
  // Partner and design outputs
  wire logic ACC_VALID, SYS_CLK_EN, IOA_CLK_EN, IOB_CLK_EN, SER0_CLK_EN, SER1_CLK_EN, SERIAL_PERIPH_IF_ZERO_CLK_EN;
  wire logic USB_CLK_EN, CONV_CLK_EN, MASTER_A_CLK_EN, MASTER_B_CLK_EN;
  wire logic [31:0] ACC_ADDR, INT_SRC;
  wire logic [19:0] WIN_SEL;
  wire logic [1:0] ACC_RESULT;
  wire logic [2:0] TIMER_CLK_EN;
  wire logic [13:0] USER_CLK_EN;
  int failures = 0;
  int tests_run = 0;
  pmr_router i_pmr_router (.*);
  pmr_master i_pmr_master (.*);
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task nx;
    @(posedge CLK_SYS);
    #1;
  endtask
  // ========================================
  // Every window back to back, low end on even windows and high end on odd, then misses
  task t_map;
    logic [31:0] bad [3] = '{32'hFFF9FFFF, 32'hFFFF0000, 32'h0};
    for (int w = 0; w < 20; w++)
    begin
      i_pmr_master.access(1'b1, 32'hFFFA0000 + (w << 14) + (w[0] ? 32'h3FFF : 32'h0));
      nx;
      chk(WIN_SEL === 20'h1 << w && ACC_RESULT === 2'h1, "window");
    end
    for (int k = 0; k < 4; k++)
    begin
      i_pmr_master.access(k < 3, k < 3 ? bad[k] : 32'h0);
      nx;
      chk(WIN_SEL === 20'h0 && ACC_RESULT === (k < 3 ? 2'h2 : 2'h0), "miss");
    end
  endtask
  // One source per group at a time, user sources in pairs; the ninth pass clears all
  task t_irq;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge CLK_SYS);
      {IRQ_PMC, IRQ_RSTC, IRQ_WDOG, IRQ_RTT, IRQ_PIT, IRQ_DEBUG, IRQ_DRAM} <= 7'h1 << i;
      {IRQ_CONV, IRQ_USB, IRQ_SERIAL_PERIPH_IF_ZERO, IRQ_SER1, IRQ_SER0, IRQ_IOB, IRQ_IOA} <= 7'h1 << i;
      {IRQ_MASTER_B, IRQ_MASTER_A, IRQ_USER} <= 16'h3 << 2 * i;
      IRQ_TIMER <= 3'h1 << i;
      nx;
      chk(INT_SRC[1] === (i < 7) && INT_SRC[9:7] === {2'h0, i < 3}, "merged");
      chk({INT_SRC[11:10], INT_SRC[6:2]} === 7'h1 << i && INT_SRC[27:12] === 16'h3 << 2 * i, "ids");
    end
    // Two channels pending; servicing one must leave source 7 set, so the handler polls all three
    @(posedge CLK_SYS);
    IRQ_TIMER <= 3'h5;
    nx;
    chk(INT_SRC[9:7] === 3'h1, "two timers");
    @(posedge CLK_SYS);
    IRQ_TIMER <= 3'h4;
    nx;
    chk(INT_SRC[9:7] === 3'h1, "timer still pending");
    @(posedge CLK_SYS);
    IRQ_TIMER <= 3'h0;
    nx;
    chk(INT_SRC[9:7] === 3'h0, "timers serviced");
  endtask
  // Clock enables follow the same identifiers
  task t_clk;
    logic [31:0] p [3] = '{32'hAAAAAAAA, 32'h55555555, 32'h0};
    foreach (p[k])
    begin
      @(posedge CLK_SYS);
      PCLK_EN_ID <= p[k];
      nx;
      chk(TIMER_CLK_EN === {3{p[k][7]}} && SYS_CLK_EN === 1'b1, "timer gate");
      chk({MASTER_B_CLK_EN, MASTER_A_CLK_EN, USER_CLK_EN} === p[k][27:12], "user gate");
      chk({CONV_CLK_EN, USB_CLK_EN, SERIAL_PERIPH_IF_ZERO_CLK_EN, SER1_CLK_EN, SER0_CLK_EN, IOB_CLK_EN, IOA_CLK_EN}
        === {p[k][11:10], p[k][6:2]}, "gate");
    end
  endtask
  // Pins pass a synchroniser, so they are held six edges
  task t_pin;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge CLK_SYS);
      {EXT_INT1_PIN, EXT_INT0_PIN, FAST_INT_PIN} <= k ? 3'h6 : 3'h1;
      repeat (6) nx;
      chk(INT_SRC[0] === !k && INT_SRC[31:28] === (k ? 4'hC : 4'h0), "pins");
    end
  endtask
  // Enable low must freeze the merged source
  task t_ce;
    @(posedge CLK_SYS);
    CE <= 1'b0;
    IRQ_PIT <= 1'b1;
    repeat (3) nx;
    chk(INT_SRC[1] === 1'b0, "frozen");
    @(posedge CLK_SYS);
    CE <= 1'b1;
    nx;
    chk(INT_SRC[1] === 1'b1, "thawed");
  endtask
  task conclude;
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
    forever #5 CLK_SYS = ~CLK_SYS;
  // Main sequence
  initial
  begin
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    nx;
    chk(WIN_SEL === 20'h0 && INT_SRC === 32'h0 && TIMER_CLK_EN === 3'h7, "reset");
    t_map;
    t_irq;
    t_clk;
    t_pin;
    t_ce;
    conclude;
  end
  // Watchdog: the run needs about a hundred cycles
  initial
  begin
    #20000;
    failures++;
    conclude;
  end
endmodule // peripheral_map_and_id_routing_bench
bind pmr_router pmr_router_sva i_pmr_router_sva (.*);
`default_nettype wire

//--- tb/pmr_master.sv
// Purpose: Bus master stand-in issuing peripheral accesses
// Assumes: Requests change just after a rising edge
// Notes: Released address lines flip so stale values never match
`timescale 1ns/10ps
`default_nettype none
module pmr_master
(
  // Clock and request
  input wire logic CLK_SYS,
  output var logic ACC_VALID = 1'b0,
  output var logic [31:0] ACC_ADDR = 32'h0
);
  // Request held until the next call
  task access(input logic v, input logic [31:0] a);
    @(posedge CLK_SYS);
    ACC_VALID <= v;
    ACC_ADDR <= v ? a : ~ACC_ADDR;
  endtask
endmodule // pmr_master
`default_nettype wire

//--- tb/pmr_router_sva.sv
// Purpose: Port assertions for the map and identifier router
// Assumes: One clock, sync active-high reset
// Notes: Outputs lag their causes by one enabled edge; pin sources lag longer through the synchroniser
`timescale 1ns/10ps
`default_nettype none
module pmr_router_sva
(
  // Clock, reset, access, routing
  input wire logic CLK_SYS, RST, CE, ACC_VALID, FAST_INT_PIN,
  input wire logic [31:0] ACC_ADDR, PCLK_EN_ID, INT_SRC,
  input wire logic [19:0] WIN_SEL,
  input wire logic [1:0] ACC_RESULT,
  input wire logic [2:0] IRQ_TIMER, TIMER_CLK_EN,
  // System interrupts
  input wire logic IRQ_DRAM, IRQ_DEBUG, IRQ_PIT, IRQ_RTT, IRQ_WDOG, IRQ_RSTC, IRQ_PMC
);
  // Reference decode; window number from address bits 18:14
  wire acc = CE & ACC_VALID;
  wire in_r = ACC_ADDR >= 32'hFFFA0000 && ACC_ADDR <= 32'hFFFEFFFF;
  wire [4:0] win = ACC_ADDR[18:14] - 5'h08;
  wire sys = IRQ_DRAM | IRQ_DEBUG | IRQ_PIT | IRQ_RTT | IRQ_WDOG | IRQ_RSTC | IRQ_PMC;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ========================================
  // Decode and routing relations
  property p_hit; acc && in_r |=> ACC_RESULT == 2'h1 && WIN_SEL == 20'h1 << $past(win); endproperty
  a_hit: assert property (p_hit) else $error("window select wrong");
  property p_miss; acc && !in_r |=> ACC_RESULT == 2'h2 && WIN_SEL == 20'h0; endproperty
  a_miss: assert property (p_miss) else $error("miss response wrong");
  property p_one; $onehot0(WIN_SEL); endproperty
  a_one: assert property (p_one) else $error("several selects");
  property p_sys; CE |=> INT_SRC[1] == $past(sys); endproperty
  a_sys: assert property (p_sys) else $error("system source wrong");
  property p_tmr; CE |=> INT_SRC[9:7] == {2'h0, $past(|IRQ_TIMER)}; endproperty
  a_tmr: assert property (p_tmr) else $error("timer source wrong");
  property p_tclk; CE |=> TIMER_CLK_EN == {3{$past(PCLK_EN_ID[7])}}; endproperty
  a_tclk: assert property (p_tclk) else $error("timer gate wrong");
  property p_fast; (CE && FAST_INT_PIN) [*6] |-> INT_SRC[0]; endproperty
  a_fast: assert property (p_fast) else $error("fast source lost");
  property p_gap; INT_SRC[29:28] == 2'h0; endproperty
  a_gap: assert property (p_gap) else $error("unused source set");
  c_hit: cover property (acc && in_r);
  c_miss: cover property (acc && !in_r);
  c_fast: cover property (INT_SRC[0]);
endmodule // pmr_router_sva
`default_nettype wire
